// ### src/jfs_cfg.svh
// Purpose: Constants for the jack function sense register bank
// Assumes: 16 function-code slots, 16-bit register words
// Notes:   Offsets, masks, field positions and reset values

`ifndef JFS_CFG_SVH
`define JFS_CFG_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define JFS_OFF_INFO 7'h68
`define JFS_OFF_SENSE 7'h6A

// ****************************************************************
// Function-code properties, one bit per code
// ****************************************************************
`define JFS_FC_SUPPORTED 16'h1DFF
`define JFS_FC_OUTPUT 16'h180F
`define JFS_FC_MONO 16'h0870

// ****************************************************************
// Field positions
// ****************************************************************
`define JFS_INFO_IV_BIT 4
`define JFS_INFO_FIP_BIT 0

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define JFS_DLY_OUT_RST 5'h02
`define JFS_DLY_IN_RST 5'h01
`define JFS_DLY_NONE 5'h00
`define JFS_DLY_RSVD 5'h1F
`define JFS_DEV_INVALID 5'h00
`define JFS_DEV_OUT_RST 5'h01
`define JFS_DEV_IN_RST 5'h11
`define JFS_ORD_RST 2'h0
`define JFS_VAL_RST 6'h00

`endif

// ### src/jfs_mem.sv
// Purpose: Small power-on-only register file, one word per function code
// Assumes: Cleared only by the asynchronous power-on reset
// Notes:   Read data come out of a register one edge after the address

`timescale 1ns/1ns
`default_nettype none

module jfs_mem
   import jfs_pkg::*;
#(
   parameter int W = 8
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic wr_en_in,
   input wire logic [3:0] wr_addr_in,
   input wire logic [W-1:0] wr_data_in,
   input wire logic [3:0] rd_addr_in,
   output logic [W-1:0] rd_data_out
);

   typedef struct packed {
      logic [15:0][W-1:0] word;
      logic [W-1:0] rd;
   } jfs_mem_st_t;

   jfs_mem_st_t st_reg;
   jfs_mem_st_t st_next;

   // Write port and registered read port
   always_comb begin
      st_next = st_reg;
      if (wr_en_in) begin
         st_next.word[wr_addr_in] = wr_data_in;
      end
      st_next.rd = st_reg.word[rd_addr_in];
   end

   // No soft reset input: contents survive everything but power-on
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rd_data_out = st_reg.rd;

endmodule : jfs_mem

`default_nettype wire

// ### src/jfs_pkg.sv
// Purpose: Types shared by the jack function sense register bank
// Assumes: Constants come from jfs_cfg.svh
// Notes:   Carriers for requests, sense reports and module state

package jfs_pkg;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic wr;
      logic rd;
      logic [6:0] addr;
      logic [15:0] wdata;
   } jfs_req_t;

   typedef struct packed {
      logic [4:0] gain;
      logic phase_inverted;
      logic [4:0] delay;
   } jfs_info_t;

   typedef struct packed {
      logic [4:0] dev;
      logic [1:0] order;
      logic [5:0] value;
   } jfs_sense_t;

   typedef struct packed {
      logic done;
      logic [3:0] fc;
      jfs_sense_t res;
   } jfs_report_t;

   // ****************************************************************
   // Module state
   // ****************************************************************
   typedef struct packed {
      jfs_sense_t [15:0] res;
      logic [15:0] iv;
      jfs_sense_t rd_res;
      logic rd_iv;
   } jfs_bank_st_t;

   typedef struct packed {
      logic caps_ok;
      logic [15:0] fip_caps;
      logic [15:0] sns_caps;
      logic pend;
      logic [6:0] pend_addr;
      logic [3:0] pend_fc;
      logic pend_tr;
      logic [15:0] rd_data;
      logic rd_valid;
      logic rd_info;
      logic rd_sense;
      logic rd_fip;
      logic rd_sns_cap;
   } jfs_top_st_t;

endpackage : jfs_pkg

// ### src/jfs_regs.sv
// Purpose: Jack function information and sense registers, per function
// Assumes: Register requests arrive on the codec's internal register port
// Notes:   Descriptor contents survive soft reset; only power-on clears
//
// Contract
// (RL1) One register pair per function code
// (RL2) Information contents cleared only at power-on
// (RL3) Only jack location survives sensing updates
// (RL4) Present flag gates writable fields, else zero
// (RL5) Mono ring selection reports no information
// (RL6) Present flag read-only, zero out of reset
// (RL7) No sensing logic: valid bit reads zero
// (RL8) Valid cleared by writing one, set by sensing
// (RL9) Delay codes: none, sample units, reserved
// (RL10) Delay defaults to internal value, writable
// (RL11) Delay measured link frame to pin
// (RL12) Inversion bit marks 180 degree shift
// (RL13) Gain magnitude 1.5 dB steps, top sign
// (RL14) Six-bit sense result read-only
// (RL15) Order field scales result by decades
// (RL16) Device code depends on slot direction
// (RL17) Output device codes as listed
// (RL18) Tip/ring selector picks jack conductor
// (RL19) Sense fields keep defaults until first sense

`include "jfs_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module jfs_regs
   import jfs_pkg::*;
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic soft_rst_in,
   input wire jfs_req_t req_in,
   input wire logic [3:0] fc_sel_in,
   input wire logic tip_ring_in,
   input wire logic [15:0] fip_strap_in,
   input wire logic [15:0] sense_strap_in,
   input wire jfs_report_t report_in,
   output logic [15:0] rd_data_out,
   output logic rd_valid_out
);

   // ****************************************************************
   // Helpers
   // ****************************************************************

   // Masks held as parameters, since a bare literal cannot be indexed
   localparam logic [15:0] SUP_MASK = `JFS_FC_SUPPORTED;
   localparam logic [15:0] OUT_MASK = `JFS_FC_OUTPUT;
   localparam logic [15:0] MONO_MASK = `JFS_FC_MONO;

   // Descriptor present for this code and conductor
   function automatic logic fip_of(input logic [15:0] caps,
                                   input logic [3:0] fc,
                                   input logic tr);
      return caps[fc] && SUP_MASK[fc] // RL1
             && !(tr && MONO_MASK[fc]); // RL5 RL18
   endfunction : fip_of

   // Internal path delay, reported in 48 kHz sample periods
   function automatic logic [4:0] dly_rst(input logic [3:0] fc);
      return OUT_MASK[fc] ? `JFS_DLY_OUT_RST : `JFS_DLY_IN_RST;
   endfunction : dly_rst

   jfs_top_st_t st_reg;
   jfs_top_st_t st_next;

   // ****************************************************************
   // Storage
   // ****************************************************************
   logic info_wr;
   logic loc_wr;
   logic iv_clr;
   logic fip_now;
   jfs_info_t info_wdata;
   jfs_info_t info_raw;
   jfs_info_t info_rd;
   logic [2:0] loc_rd;
   jfs_sense_t sense_rd;
   logic iv_rd;

   // Storage holds the value xor its default so a zero reset
   // still yields each slot's own internal delay
   jfs_mem #(
      .W($bits(jfs_info_t))
   ) u_info_mem (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .wr_en_in(info_wr),
      .wr_addr_in(fc_sel_in),
      .wr_data_in(info_wdata),
      .rd_addr_in(fc_sel_in),
      .rd_data_out(info_raw)
   );

   // Jack location, written by firmware, power-on reset only
   jfs_mem #(
      .W(3)
   ) u_loc_mem (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .wr_en_in(loc_wr),
      .wr_addr_in(fc_sel_in),
      .wr_data_in(req_in.wdata[15:13]),
      .rd_addr_in(fc_sel_in),
      .rd_data_out(loc_rd)
   );

   // Sense results, restored to defaults by soft reset as well
   jfs_sense_bank u_bank (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .soft_rst_in(soft_rst_in),
      .caps_in(st_reg.sns_caps),
      .report_in(report_in),
      .iv_clr_in(iv_clr),
      .iv_clr_fc_in(fc_sel_in),
      .rd_fc_in(fc_sel_in),
      .rd_res_out(sense_rd),
      .rd_iv_out(iv_rd)
   );

   // ****************************************************************
   // Write decode
   // ****************************************************************

   // Writes to absent descriptors are dropped, fields stay zero
   always_comb begin
      fip_now = fip_of(st_reg.fip_caps, fc_sel_in, tip_ring_in);
      info_wr = req_in.wr && req_in.addr == `JFS_OFF_INFO
                && fip_now; // RL4
      loc_wr = req_in.wr && req_in.addr == `JFS_OFF_SENSE
               && fip_now; // RL4 RL3
      iv_clr = req_in.wr && req_in.addr == `JFS_OFF_INFO
               && req_in.wdata[`JFS_INFO_IV_BIT]
               && st_reg.sns_caps[fc_sel_in]; // RL8
      info_wdata.gain = req_in.wdata[15:11]; // RL13
      info_wdata.phase_inverted = req_in.wdata[10]; // RL12
      // Reserved delay code is stored as no information
      info_wdata.delay = (req_in.wdata[9:5] == `JFS_DLY_RSVD) ?
                         `JFS_DLY_NONE : req_in.wdata[9:5]; // RL9
      info_wdata.delay = info_wdata.delay ^ dly_rst(fc_sel_in); // RL10
      info_rd = info_raw;
      info_rd.delay = info_raw.delay ^ dly_rst(st_reg.pend_fc); // RL11
   end

   // ****************************************************************
   // Read path and strap capture
   // ****************************************************************

   // Straps caught one edge after release; until then nothing present
   always_comb begin
      st_next = st_reg;
      if (!st_reg.caps_ok) begin
         st_next.caps_ok = 1'b1;
         st_next.fip_caps = fip_strap_in; // RL6
         st_next.sns_caps = sense_strap_in; // RL7
      end
      st_next.pend = req_in.rd;
      st_next.pend_addr = req_in.addr;
      st_next.pend_fc = fc_sel_in;
      st_next.pend_tr = tip_ring_in;
      st_next.rd_valid = st_reg.pend;
      st_next.rd_info = st_reg.pend && st_reg.pend_addr == `JFS_OFF_INFO;
      st_next.rd_sense = st_reg.pend
                         && st_reg.pend_addr == `JFS_OFF_SENSE;
      st_next.rd_fip = fip_of(st_reg.fip_caps, st_reg.pend_fc,
                              st_reg.pend_tr);
      st_next.rd_sns_cap = st_reg.sns_caps[st_reg.pend_fc];
      st_next.rd_data = 16'h0000;
      if (st_next.rd_info) begin
         // Absent descriptor reads zero fields, flag zero
         st_next.rd_data[`JFS_INFO_IV_BIT] = iv_rd; // RL7 RL8
         if (st_next.rd_fip) begin
            st_next.rd_data[15:5] = info_rd; // RL4 RL12 RL13
            st_next.rd_data[`JFS_INFO_FIP_BIT] = 1'b1; // RL6
         end
      end else if (st_next.rd_sense) begin
         // Device code, order and result are read-only
         st_next.rd_data[12:0] = sense_rd; // RL14 RL15 RL16 RL17
         if (st_next.rd_fip) begin
            st_next.rd_data[15:13] = loc_rd; // RL3 RL4
         end
      end
   end

   // Single process registers all control state
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_reg <= '0; // RL2 RL6
      end else begin
         st_reg <= st_next;
      end
   end

   assign rd_data_out = st_reg.rd_data;
   assign rd_valid_out = st_reg.rd_valid;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!arst_n_in);

   // Back-to-back reads are legal, so the answer is checked both ways
   property p_rd_latency;
      req_in.rd |-> ##2 rd_valid_out;
   endproperty
   a_rd_latency: assert property (p_rd_latency) // RL1
      else $error("read answer not two edges after request");

   property p_rd_no_spurious;
      rd_valid_out |-> $past(req_in.rd, 2);
   endproperty
   a_rd_no_spurious: assert property (p_rd_no_spurious) // RL1
      else $error("read answer without a request");

   property p_mono_ring;
      req_in.rd && req_in.addr == `JFS_OFF_INFO && tip_ring_in
      && MONO_MASK[fc_sel_in] |-> ##2 !rd_data_out[0];
   endproperty
   a_mono_ring: assert property (p_mono_ring) // RL5
      else $error("mono ring read shows information present");

   property p_absent_zero;
      rd_valid_out && st_reg.rd_info && !rd_data_out[0]
      |-> rd_data_out[15:5] == 11'h000;
   endproperty
   a_absent_zero: assert property (p_absent_zero) // RL4
      else $error("absent descriptor fields not zero");

   property p_loc_zero;
      rd_valid_out && st_reg.rd_sense && !st_reg.rd_fip
      |-> rd_data_out[15:13] == 3'h0;
   endproperty
   a_loc_zero: assert property (p_loc_zero) // RL4
      else $error("absent descriptor shows jack location");

   property p_fip_por;
      req_in.rd && req_in.addr == `JFS_OFF_INFO && !st_reg.caps_ok
      |-> ##2 rd_data_out[0] == 1'b0;
   endproperty
   a_fip_por: assert property (p_fip_por) // RL6
      else $error("present flag set straight out of reset");

   property p_iv_nocap;
      rd_valid_out && st_reg.rd_info && !st_reg.rd_sns_cap
      |-> !rd_data_out[4];
   endproperty
   a_iv_nocap: assert property (p_iv_nocap) // RL7
      else $error("valid bit set without sensing logic");

   property p_wr_readback;
      req_in.wr && req_in.addr == `JFS_OFF_INFO && fip_now
      ##1 !req_in.wr && $stable(fc_sel_in) && $stable(tip_ring_in)
      ##1 (req_in.rd && req_in.addr == `JFS_OFF_INFO
           && $stable(fc_sel_in) && $stable(tip_ring_in))
      |-> ##2 rd_data_out[15:10] == $past(req_in.wdata[15:10], 4);
   endproperty
   a_wr_readback: assert property (p_wr_readback) // RL4 RL13
      else $error("gain or inversion not read back as written");

   property p_soft_keeps_info;
      soft_rst_in && !req_in.wr && !$past(req_in.wr) && $stable(fc_sel_in)
      ##1 !req_in.wr && $stable(fc_sel_in)
      ##1 (req_in.rd && req_in.addr == `JFS_OFF_INFO && $stable(fc_sel_in))
      |-> ##2 rd_data_out[15:5] == $past(info_rd, 4) || !rd_data_out[0];
   endproperty
   a_soft_keeps_info: assert property (p_soft_keeps_info) // RL2
      else $error("soft reset disturbed descriptor contents");

   c_info_read: cover property (rd_valid_out && st_reg.rd_info
                                && rd_data_out[0]);
   c_sense_done: cover property (report_in.done ##[1:20] rd_valid_out
                                 && st_reg.rd_sense);
   c_iv_clear: cover property (iv_clr ##[1:10] rd_valid_out
                               && st_reg.rd_info);

endmodule : jfs_regs

`default_nettype wire

// ### src/jfs_sense_bank.sv
// Purpose: Per-function sense results and information-valid flags
// Assumes: Sense reports arrive as one-cycle pulses with their code
// Notes:   Soft reset restores defaults; a report in the same cycle wins

`include "jfs_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module jfs_sense_bank
   import jfs_pkg::*;
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic soft_rst_in,
   input wire logic [15:0] caps_in,
   input wire jfs_report_t report_in,
   input wire logic iv_clr_in,
   input wire logic [3:0] iv_clr_fc_in,
   input wire logic [3:0] rd_fc_in,
   output jfs_sense_t rd_res_out,
   output logic rd_iv_out
);

   // Mask as a parameter, since a bare literal cannot be indexed
   localparam logic [15:0] OUT_MASK = `JFS_FC_OUTPUT;

   // Default device code depends on the slot's direction
   function automatic jfs_sense_t [15:0] rst_res();
      jfs_sense_t [15:0] r;
      for (int i = 0; i < 16; i++) begin
         r[i].dev = OUT_MASK[i] ? `JFS_DEV_OUT_RST : `JFS_DEV_IN_RST;
         r[i].order = `JFS_ORD_RST;
         r[i].value = `JFS_VAL_RST;
      end
      return r;
   endfunction : rst_res

   localparam jfs_sense_t [15:0] RST_RES = rst_res();
   localparam jfs_bank_st_t RST_ST = '{res: RST_RES, iv: 16'h0000,
                                       rd_res: RST_RES[0], rd_iv: 1'b0};

   jfs_bank_st_t st_reg;
   jfs_bank_st_t st_next;

   // Clear first, then the sense report, so a report is never lost
   always_comb begin
      st_next = st_reg;
      if (soft_rst_in) begin
         st_next.res = RST_RES; // RL19
         st_next.iv = 16'h0000;
      end
      if (iv_clr_in) begin
         st_next.iv[iv_clr_fc_in] = 1'b0; // RL8
      end
      if (report_in.done && caps_in[report_in.fc]) begin
         st_next.res[report_in.fc] = report_in.res; // RL3 RL19
         st_next.iv[report_in.fc] = 1'b1; // RL8
      end
      st_next.rd_res = st_reg.res[rd_fc_in];
      st_next.rd_iv = st_reg.iv[rd_fc_in];
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_reg <= RST_ST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rd_res_out = st_reg.rd_res;
   assign rd_iv_out = st_reg.rd_iv;

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_iv_set;
      @(posedge clk_in) disable iff (!arst_n_in)
      report_in.done && caps_in[report_in.fc] |=> st_reg.iv[$past(report_in.fc)];
   endproperty
   a_iv_set: assert property (p_iv_set) // RL8
      else $error("valid flag not set by finished sense");

   property p_iv_nocap;
      @(posedge clk_in) disable iff (!arst_n_in)
      (st_reg.iv & ~caps_in) == 16'h0000;
   endproperty
   a_iv_nocap: assert property (p_iv_nocap) // RL7
      else $error("valid flag set on slot without sensing");

endmodule : jfs_sense_bank

`default_nettype wire

// ### verif/jfs_sense_model.sv
// Purpose: Behavioural sensing circuitry that issues sense reports
// Assumes: One report at a time, launched just after a rising edge
// Notes:   Idle result lines carry the inverse of the last report

`timescale 1ns/1ns
`default_nettype none

module jfs_sense_model
   import jfs_pkg::*;
(
   input wire logic clk_in,
   output var jfs_report_t report_out
);
   // ****************************************************************
   // Report launcher
   // ****************************************************************
   initial begin
      report_out = '0;
   end

   // One-cycle done pulse; stale fields scrambled so nothing leans on them
   task automatic send(input logic [3:0] fc, input jfs_sense_t res);
      @(posedge clk_in);
      report_out <= '{done: 1'b1, fc: fc, res: res};
      @(posedge clk_in);
      report_out <= '{done: 1'b0, fc: ~fc, res: ~res};
   endtask : send

endmodule : jfs_sense_model

`default_nettype wire

// ### verif/testbench.sv
// Purpose: Self-checking bench for the jack function sense registers
// Assumes: Straps fixed from time zero, caught after each power-on
// Notes:   A shadow model of every slot predicts each read word but the unmapped-offset read, which expects zero

`include "jfs_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module testbench
   import jfs_pkg::*;
;
   localparam logic [15:0] SUP = `JFS_FC_SUPPORTED;
   localparam logic [15:0] OUTS = `JFS_FC_OUTPUT;
   localparam logic [15:0] MONO = `JFS_FC_MONO;
   localparam logic [15:0] FUNC_INFO_PRESENT = 16'h1DF7;
   localparam logic [15:0] SNS = 16'h1DFE;

   logic clk_in;
   logic arst_n_in;
   logic soft_rst_in;
   jfs_req_t req_in;
   logic [3:0] fc_sel_in;
   logic tip_ring_in;
   jfs_report_t report_in;
   logic [15:0] rd_data_out;
   logic rd_valid_out;
   int n_errors;
   int tests_run;
   logic [4:0] m_gain [16];
   logic m_inv [16];
   logic [4:0] m_dly [16];
   logic [2:0] m_loc [16];
   logic m_iv [16];
   jfs_sense_t m_res [16];

   // ****************************************************************
   // Design, partner and clock
   // ****************************************************************
   jfs_regs DUT (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .soft_rst_in(soft_rst_in),
      .req_in(req_in),
      .fc_sel_in(fc_sel_in),
      .tip_ring_in(tip_ring_in),
      .fip_strap_in(FUNC_INFO_PRESENT),
      .sense_strap_in(SNS),
      .report_in(report_in),
      .rd_data_out(rd_data_out),
      .rd_valid_out(rd_valid_out)
   );

   jfs_sense_model u_sense (
      .clk_in(clk_in),
      .report_out(report_in)
   );

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   // ****************************************************************
   // Shadow model
   // ****************************************************************
   // Mono slots lose their descriptor on the ring conductor
   function automatic logic pres(input int f, input logic t);
      return FUNC_INFO_PRESENT[f] & SUP[f] & !(MONO[f] & t);
   endfunction : pres

   function automatic logic [15:0] exp_info(input int f, input logic t);
      if (pres(f, t)) return {m_gain[f], m_inv[f], m_dly[f], m_iv[f], 4'h1};
      return {11'h000, m_iv[f], 4'h0};
   endfunction : exp_info

   function automatic logic [15:0] exp_sns(input int f, input logic t);
      return {(pres(f, t) ? m_loc[f] : 3'h0), m_res[f]};
   endfunction : exp_sns

   // Soft reset only touches sense results and valid flags; power-on clears all
   task automatic model_reset(input logic power);
      for (int f = 0; f < 16; f++) begin
         if (power) begin
            m_gain[f] = 5'h00;
            m_inv[f] = 1'b0;
            m_dly[f] = OUTS[f] ? `JFS_DLY_OUT_RST : `JFS_DLY_IN_RST;
            m_loc[f] = 3'h0;
         end
         m_iv[f] = 1'b0;
         m_res[f] = {(OUTS[f] ? `JFS_DEV_OUT_RST : `JFS_DEV_IN_RST), 8'h00};
      end
   endtask : model_reset

   // ****************************************************************
   // Register port tasks
   // ****************************************************************
   task automatic fail(input string msg);
      $display("ERROR at %0t: %s", $time, msg);
      n_errors++;
   endtask : fail

   // Read answer lands exactly two edges after the request edge
   task automatic rd(input logic [6:0] a, input logic [3:0] f, input logic t,
                     input logic [15:0] e);
      @(posedge clk_in);
      req_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      fc_sel_in <= f;
      tip_ring_in <= t;
      @(posedge clk_in);
      req_in <= '0;
      @(posedge clk_in);
      #1;
      tests_run++;
      if (rd_valid_out !== 1'b1 || rd_data_out !== e) begin
         $display("ERROR at %0t: read %h fc %h got %h exp %h", $time, a, f,
                  rd_data_out, e);
         n_errors++;
      end
   endtask : rd

   task automatic wr(input logic [6:0] a, input logic [3:0] f, input logic t,
                     input logic [15:0] d);
      @(posedge clk_in);
      req_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      fc_sel_in <= f;
      tip_ring_in <= t;
      @(posedge clk_in);
      req_in <= '0;
      if (a == `JFS_OFF_INFO && pres(f, t)) begin
         m_gain[f] = d[15:11];
         m_inv[f] = d[10];
         m_dly[f] = (d[9:5] == `JFS_DLY_RSVD) ? `JFS_DLY_NONE : d[9:5];
      end
      if (a == `JFS_OFF_INFO && d[4] && SNS[f] && SUP[f]) m_iv[f] = 1'b0;
      if (a == `JFS_OFF_SENSE && pres(f, t)) m_loc[f] = d[15:13];
   endtask : wr

   // Software side of the valid handshake lives in wr above
   task automatic report(input logic [3:0] f, input jfs_sense_t r);
      u_sense.send(f, r);
      if (SNS[f] && SUP[f]) begin
         m_res[f] = r;
         m_iv[f] = 1'b1;
      end
   endtask : report

   task automatic check_all();
      for (int f = 0; f < 16; f++) begin
         for (int t = 0; t < 2; t++) begin
            rd(`JFS_OFF_INFO, 4'(f), 1'(t), exp_info(f, 1'(t)));
            rd(`JFS_OFF_SENSE, 4'(f), 1'(t), exp_sns(f, 1'(t)));
         end
      end
   endtask : check_all

   // ****************************************************************
   // Verdict and watchdog
   // ****************************************************************
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict

   // Whole run is about 1100 cycles; the 30000-cycle limit is over twenty times that, so reaching it is a hang
   initial begin
      #300000;
      fail("watchdog expired");
      give_verdict();
   end

   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial begin
      n_errors = 0;
      tests_run = 0;
      arst_n_in = 1'b0;
      soft_rst_in = 1'b0;
      req_in = '0;
      fc_sel_in = 4'h0;
      tip_ring_in = 1'b0;
      model_reset(1'b1);
      repeat (6) @(posedge clk_in);
      arst_n_in <= 1'b1;
      check_all();
      $display("test defaults done");
      for (int d = 0; d < 9; d++) begin
         report(4'h2, {5'(d), 2'(d), 6'(d * 7)});
         rd(`JFS_OFF_SENSE, 4'h2, 1'b0, exp_sns(2, 1'b0));
      end
      report(4'h0, 13'h1FFF);
      report(4'h4, {5'h14, 2'h3, 6'h2A});
      check_all();
      $display("test sense done");
      wr(`JFS_OFF_INFO, 4'h4, 1'b0, 16'hFFE0);
      rd(`JFS_OFF_INFO, 4'h4, 1'b0, exp_info(4, 1'b0));
      for (int f = 0; f < 16; f++) begin
         wr(`JFS_OFF_INFO, 4'(f), f[2], {5'(f + 17), f[0], 5'(f), 5'h10});
         wr(`JFS_OFF_SENSE, 4'(f), f[2], {3'(f), 13'h1ABC});
      end
      check_all();
      rd(7'h6C, 4'h0, 1'b0, 16'h0000);
      $display("test writes done");
      @(posedge clk_in);
      soft_rst_in <= 1'b1;
      @(posedge clk_in);
      soft_rst_in <= 1'b0;
      model_reset(1'b0);
      check_all();
      $display("test soft reset done");
      @(posedge clk_in);
      arst_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      arst_n_in <= 1'b1;
      model_reset(1'b1);
      check_all();
      $display("test power-on done");
      give_verdict();
   end

endmodule : testbench

`default_nettype wire
